// ==== core/crp_classify.sv ====
// Purpose: Combinational classifier of one response primitive word.
// Assumes: Word is stable while it is examined.
// Notes:   Order of the checks sets priority among overlapping codes.
`include "crp_map.svh"
`default_nettype none
module crp_classify (
  // Primitive word.
  input  wire logic [15:0]       word_in,
  // Decoded kind.
  output crp_pkg::crp_kind_t     kind_out
);
  import crp_pkg::*;
  logic [5:0] fn;
  logic [4:0] lo;
  assign fn = word_in[`CRP_FN_HI:`CRP_FN_LO];
  assign lo = word_in[12:8];

  // Picks the kind; anything unmatched is a violation.
  always_comb begin
    kind_out = CRP_K_VIOL;
    if (fn == `CRP_FN_ZERO || fn == `CRP_FN_ONES) begin
      kind_out = CRP_K_VIOL;
    end else if (fn == `CRP_FN_RSV0 || fn == `CRP_FN_RSV1 ||
                 fn == `CRP_FN_RSV2 || fn == `CRP_FN_RSV3 ||
                 fn == `CRP_FN_RSV4) begin
      kind_out = CRP_K_VIOL;
    end else if (fn == `CRP_FN_BUSY && word_in[`CRP_CA_BIT]) begin
      kind_out = CRP_K_BUSY;
    end else if (fn == `CRP_FN_OPWORD) begin
      kind_out = CRP_K_OPWORD;
    end else if (fn == `CRP_FN_SUPCHK) begin
      kind_out = CRP_K_SUPCHK;
    end else if (lo[4:3] == 2'b10) begin
      kind_out = CRP_K_EVALDATA;
    end else if (lo == `CRP_LO_WRPREV && word_in[13]) begin
      kind_out = CRP_K_WRPREV;
    end else if (lo == `CRP_LO_CPREGS) begin
      kind_out = CRP_K_CPREGS;
    end else if (lo[4:1] == `CRP_HI4_STATUS) begin
      kind_out = (word_in[7:0] == 8'h00) ? CRP_K_STATUS : CRP_K_VIOL;
    end else if (lo == `CRP_LO_TAKEADR) begin
      kind_out = CRP_K_TAKEADR;
    end else if (lo == `CRP_LO_MPREGS) begin
      kind_out = (word_in[7:0] == 8'h00) ? CRP_K_MPREGS : CRP_K_VIOL;
    end else if (lo[4:1] == `CRP_HI4_NULL && !word_in[13]) begin
      kind_out = CRP_K_NULL;
    end else if (lo == `CRP_LO_EVALEA && !word_in[13]) begin
      kind_out = (word_in[7:0] == 8'h00) ? CRP_K_EVALEA : CRP_K_VIOL;
    end else if (lo == `CRP_LO_SINGLE) begin
      kind_out = CRP_K_SINGLE;
    end else if (lo == `CRP_LO_CTLREG) begin
      kind_out = (word_in[7:0] == 8'h00) ? CRP_K_CTLREG : CRP_K_VIOL;
    end else if (lo == `CRP_LO_STACK) begin
      kind_out = CRP_K_STACK;
    end else if (lo == `CRP_LO_ISTREAM && !word_in[13]) begin
      kind_out = CRP_K_ISTREAM;
    end else if (!word_in[15] && !word_in[13] &&
                 lo == `CRP_LO_PREEXC) begin
      kind_out = CRP_K_PREEXC;
    end else if (!word_in[15] && !word_in[13] &&
                 lo == `CRP_LO_MIDEXC) begin
      kind_out = CRP_K_MIDEXC;
    end else if (!word_in[15] && !word_in[13] &&
                 lo == `CRP_LO_POSTEXC) begin
      kind_out = CRP_K_POSTEXC;
    end
  end
endmodule
`default_nettype wire

// ==== core/crp_decoder.sv ====
// Purpose: Registered decoder of coprocessor response primitives.
// Assumes: One primitive is offered per cycle by a valid strobe.
// Notes:   All outputs are registered; results appear one cycle later.
`include "crp_map.svh"
`default_nettype none
module crp_decoder (
  // Clock and reset.
  input  wire logic              mclk_in,
  input  wire logic              rst_b_in,
  // Primitive read from the response register.
  input  wire logic              prim_valid_in,
  input  wire logic [15:0]       prim_word_in,
  // Processor context.
  input  wire logic              trace_pending_in,
  input  wire logic              irq_pending_in,
  // Decoded primitive.
  output logic                   dec_valid_out,
  output crp_pkg::crp_kind_t     kind_out,
  output logic                   protocol_violation_out,
  output logic                   come_again_flag_out,
  output logic                   pass_program_counter_flag_out,
  output logic                   transfer_direction_flag_out,
  output logic                   include_status_flag_out,
  output logic                   interrupts_allowed_flag_out,
  output logic                   processing_finished_flag_out,
  output logic                   condition_result_flag_out,
  output logic                   addr_reg_sel_out,
  output logic [2:0]             reg_num_out,
  output logic [2:0]             valid_mode_out,
  output logic [7:0]             length_out,
  output logic [7:0]             vector_out,
  // Dialogue control.
  output logic                   dialogue_active_out,
  output logic                   dialogue_end_out,
  output logic                   service_irq_out
);
  import crp_pkg::*;
  crp_kind_t  kind_nxt;
  crp_state_t state_r;
  logic       finished_null;
  logic       ends_now;

  crp_classify u_classify (
    .word_in  (prim_word_in),
    .kind_out (kind_nxt)
  );

  // A finished null: come-again clear and processing-finished set.
  assign finished_null = (kind_nxt == CRP_K_NULL) &&
                         !prim_word_in[`CRP_CA_BIT] && prim_word_in[1];
  // Dialogue ends on come-again clear without trace; under trace, on a finished null or a post-exception request.
  assign ends_now = trace_pending_in ?
                    (finished_null || kind_nxt == CRP_K_POSTEXC)
                    : !prim_word_in[`CRP_CA_BIT];

  // Registers the decoded kind and all fields of the word.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dec_valid_out                 <= 1'b0;
      kind_out                      <= CRP_K_NONE;
      protocol_violation_out        <= 1'b0;
      come_again_flag_out           <= 1'b0;
      pass_program_counter_flag_out <= 1'b0;
      transfer_direction_flag_out   <= 1'b0;
      include_status_flag_out       <= 1'b0;
      interrupts_allowed_flag_out   <= 1'b0;
      processing_finished_flag_out  <= 1'b0;
      condition_result_flag_out     <= 1'b0;
      addr_reg_sel_out              <= 1'b0;
      reg_num_out                   <= 3'h0;
      valid_mode_out                <= 3'h0;
      length_out                    <= 8'h00;
      vector_out                    <= 8'h00;
    end else begin
      dec_valid_out          <= prim_valid_in;
      protocol_violation_out <= prim_valid_in &&
                                kind_nxt == CRP_K_VIOL;
      if (prim_valid_in) begin
        kind_out                      <= kind_nxt;
        come_again_flag_out           <= prim_word_in[`CRP_CA_BIT];
        pass_program_counter_flag_out <= prim_word_in[`CRP_PC_BIT];
        transfer_direction_flag_out   <= prim_word_in[`CRP_DR_BIT];
        include_status_flag_out       <= prim_word_in[8];
        interrupts_allowed_flag_out   <= prim_word_in[8];
        processing_finished_flag_out  <= prim_word_in[1];
        condition_result_flag_out     <= prim_word_in[0];
        addr_reg_sel_out              <= prim_word_in[3];
        reg_num_out                   <= prim_word_in[2:0];
        valid_mode_out                <= prim_word_in[10:8];
        length_out                    <= prim_word_in[7:0];
        vector_out                    <= prim_word_in[7:0];
      end
    end
  end

  // Tracks the dialogue and raises its end and interrupt service pulses.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r          <= CRP_S_IDLE;
      dialogue_end_out <= 1'b0;
      service_irq_out  <= 1'b0;
    end else begin
      dialogue_end_out <= 1'b0;
      service_irq_out  <= 1'b0;
      case (state_r)
        CRP_S_IDLE: begin
          if (prim_valid_in) begin
            state_r <= CRP_S_POLL;
          end
        end
        CRP_S_POLL: begin
          state_r <= CRP_S_POLL;
        end
        default: begin
          // Interrupt service holds the dialogue until the next read.
          if (prim_valid_in) begin
            state_r <= CRP_S_POLL;
          end
        end
      endcase
      if (prim_valid_in) begin
        if (kind_nxt == CRP_K_VIOL || ends_now) begin
          state_r          <= CRP_S_IDLE;
          dialogue_end_out <= 1'b1;
        end
        // Interrupt window on a null that allows it.
        if (kind_nxt == CRP_K_NULL && prim_word_in[8] && irq_pending_in &&
            (prim_word_in[`CRP_CA_BIT] ||
             (trace_pending_in && !prim_word_in[1]))) begin
          state_r         <= CRP_S_HOLD;
          service_irq_out <= 1'b1;
        end
      end
    end
  end

  // Active flag mirrors the state in a register of its own.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dialogue_active_out <= 1'b0;
    end else if (prim_valid_in) begin
      dialogue_active_out <= !(kind_nxt == CRP_K_VIOL || ends_now);
    end
  end

  // Kind and field checks, one per family but the supervisor check; the exception check covers post only.
  AST_VIOL_ZERO: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && prim_word_in[13:8] == 6'h00
    |=> protocol_violation_out) else $error("zero code not flagged");
  AST_VIOL_RSV: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in &&
    prim_word_in[13:8] inside {6'h0B, 6'h1B, 6'h1F, 6'h2B, 6'h3B}
    |=> protocol_violation_out) else $error("reserved not flagged");
  AST_CPREGS: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && prim_word_in[12:8] == 5'h01
    |=> kind_out == CRP_K_CPREGS && length_out == $past(prim_word_in[7:0]))
    else $error("cp regs misdecoded");
  AST_STATUS: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && prim_word_in[12:9] == 4'h1 && prim_word_in[7:0] == 8'h00
    |=> kind_out == CRP_K_STATUS &&
        include_status_flag_out == $past(prim_word_in[8]))
    else $error("status transfer misdecoded");
  AST_TAKEADR: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && prim_word_in[12:8] == 5'h05
    |=> kind_out == CRP_K_TAKEADR && length_out == $past(prim_word_in[7:0]))
    else $error("take address misdecoded");
  AST_MPREGS: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && prim_word_in[12:0] == 13'h0600
    |=> kind_out == CRP_K_MPREGS) else $error("mp regs misdecoded");
  AST_EVALEA: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && prim_word_in[13:0] == 14'h0A00
    |=> kind_out == CRP_K_EVALEA) else $error("eval address misdecoded");
  AST_SINGLE: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && prim_word_in[12:8] == 5'h0C
    |=> kind_out == CRP_K_SINGLE && reg_num_out == $past(prim_word_in[2:0]) &&
        addr_reg_sel_out == $past(prim_word_in[3]))
    else $error("register number wrong");
  AST_CTLREG: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && prim_word_in[12:0] == 13'h0D00
    |=> kind_out == CRP_K_CTLREG) else $error("control reg misdecoded");
  AST_STACK: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && prim_word_in[12:8] == 5'h0E
    |=> kind_out == CRP_K_STACK &&
        transfer_direction_flag_out == $past(prim_word_in[13]))
    else $error("stack transfer misdecoded");
  AST_ISTREAM: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && prim_word_in[13:8] == 6'h0F
    |=> kind_out == CRP_K_ISTREAM && length_out == $past(prim_word_in[7:0]))
    else $error("instruction stream misdecoded");
  AST_EVALDATA: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && prim_word_in[12:11] == 2'b10
    |=> kind_out == CRP_K_EVALDATA &&
        valid_mode_out == $past(prim_word_in[10:8]))
    else $error("eval data missed");
  AST_WRPREV: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && prim_word_in[13:8] == 6'h20
    |=> kind_out == CRP_K_WRPREV && length_out == $past(prim_word_in[7:0]))
    else $error("write previous misdecoded");
  AST_NULL: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && prim_word_in[13:9] == 5'h04
    |=> kind_out == CRP_K_NULL &&
        interrupts_allowed_flag_out == $past(prim_word_in[8]) &&
        processing_finished_flag_out == $past(prim_word_in[1]))
    else $error("null misdecoded");
  AST_EXC: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && !prim_word_in[15] && prim_word_in[13:8] == 6'h1E
    |=> kind_out == CRP_K_POSTEXC && vector_out == $past(prim_word_in[7:0]))
    else $error("exception request misdecoded");
  AST_OPWORD: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && prim_word_in[13:8] == 6'h07
    |=> kind_out == CRP_K_OPWORD) else $error("operation word missed");
  AST_BUSY: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && prim_word_in[15] && prim_word_in[13:8] == 6'h24
    |=> kind_out == CRP_K_BUSY) else $error("busy missed");
  // Dialogue checks.
  AST_END_NOTRACE: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && !trace_pending_in && !prim_word_in[15]
    |=> dialogue_end_out && !dialogue_active_out)
    else $error("dialogue not ended");
  AST_TRACE_POLL: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && trace_pending_in && kind_nxt == CRP_K_NULL &&
    !prim_word_in[1] |=> !dialogue_end_out)
    else $error("ended before finished");
  AST_IRQ: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    prim_valid_in && kind_nxt == CRP_K_NULL && prim_word_in[15] &&
    prim_word_in[8] && irq_pending_in |=> service_irq_out)
    else $error("interrupt window missed");
  AST_HOLD: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    service_irq_out |-> state_r == CRP_S_HOLD)
    else $error("interrupt service without hold");
  AST_ACTIVE: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    dialogue_active_out == (state_r != CRP_S_IDLE))
    else $error("active flag disagrees with state");
endmodule
`default_nettype wire

// ==== core/crp_map.svh ====
// Purpose: Constants for the coprocessor response primitive decoder.
// Assumes: Response words are 16 bits wide.
// Notes:   Function codes are taken from bits 13 down to 8.
`ifndef CRP_MAP_SVH
`define CRP_MAP_SVH
`define CRP_FN_HI      13
`define CRP_FN_LO      8
`define CRP_CA_BIT     15
`define CRP_PC_BIT     14
`define CRP_DR_BIT     13
`define CRP_FN_ZERO    6'h00
`define CRP_FN_ONES    6'h3F
`define CRP_FN_RSV0    6'h0B
`define CRP_FN_RSV1    6'h1B
`define CRP_FN_RSV2    6'h1F
`define CRP_FN_RSV3    6'h2B
`define CRP_FN_RSV4    6'h3B
`define CRP_LO_CPREGS  5'h01
`define CRP_LO_TAKEADR 5'h05
`define CRP_LO_MPREGS  5'h06
`define CRP_LO_EVALEA  5'h0A
`define CRP_LO_SINGLE  5'h0C
`define CRP_LO_CTLREG  5'h0D
`define CRP_LO_STACK   5'h0E
`define CRP_LO_ISTREAM 5'h0F
`define CRP_LO_PREEXC  5'h1C
`define CRP_LO_MIDEXC  5'h1D
`define CRP_LO_POSTEXC 5'h1E
`define CRP_LO_WRPREV  5'h00
`define CRP_HI4_STATUS 4'h1
`define CRP_HI4_NULL   4'h4
`define CRP_FN_OPWORD  6'h07
`define CRP_FN_SUPCHK  6'h04
`define CRP_FN_BUSY    6'h24
`endif

// ==== core/crp_pkg.sv ====
// Purpose: Types for the coprocessor response primitive decoder.
// Assumes: Nothing beyond the constants header.
// Notes:   Primitive kinds are one enumeration shared by both modules.
`default_nettype none
package crp_pkg;
  typedef enum logic [4:0] {
    CRP_K_NONE     = 5'h00,
    CRP_K_CPREGS   = 5'h01,
    CRP_K_STATUS   = 5'h02,
    CRP_K_TAKEADR  = 5'h03,
    CRP_K_MPREGS   = 5'h04,
    CRP_K_EVALEA   = 5'h05,
    CRP_K_SINGLE   = 5'h06,
    CRP_K_CTLREG   = 5'h07,
    CRP_K_STACK    = 5'h08,
    CRP_K_ISTREAM  = 5'h09,
    CRP_K_EVALDATA = 5'h0A,
    CRP_K_WRPREV   = 5'h0B,
    CRP_K_NULL     = 5'h0C,
    CRP_K_PREEXC   = 5'h0D,
    CRP_K_MIDEXC   = 5'h0E,
    CRP_K_POSTEXC  = 5'h0F,
    CRP_K_OPWORD   = 5'h10,
    CRP_K_SUPCHK   = 5'h11,
    CRP_K_BUSY     = 5'h12,
    CRP_K_VIOL     = 5'h13
  } crp_kind_t;
  // Dialogue states, Gray coded along idle, wait, hold.
  typedef enum logic [1:0] {
    CRP_S_IDLE = 2'b00,
    CRP_S_POLL = 2'b01,
    CRP_S_HOLD = 2'b11
  } crp_state_t;
endpackage
`default_nettype wire

// ==== test/crp_cop_model.sv ====
// Purpose: Coprocessor model that answers with response primitives.
// Assumes: The bench asks for one word at a time.
// Notes:   Idle response lines toggle so a stale word never looks valid.
`default_nettype none
module crp_cop_model (
  // Clock and reset.
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  // Requests from the bench.
  input  wire logic        req_in,
  input  wire logic [15:0] req_word_in,
  input  wire logic        busy_in,
  // Primitive towards the decoder.
  output logic             prim_valid_out,
  output logic [15:0]      prim_word_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // One word per request; while still working the finished flag is clear.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prim_valid_out <= 1'b0;
      prim_word_out  <= 16'h0000;
    end else if (req_in) begin
      prim_valid_out <= 1'b1;
      prim_word_out  <= req_word_in & {14'h3FFF, ~busy_in, 1'b1};
    end else begin
      prim_valid_out <= 1'b0;
      prim_word_out  <= ~prim_word_out;
    end
  end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Purpose: Self-checking bench for the response primitive decoder.
// Assumes: Words reach the decoder through the coprocessor model.
// Notes:   Results are read one cycle after the decoder takes a word.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import crp_pkg::*;
  logic        mclk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        req = 1'b0, busy = 1'b0, trace = 1'b0, irq = 1'b0, pvld;
  logic [15:0] word = 16'h0000, pword;
  crp_kind_t   kind;
  logic        dv, viol, ca, pc, dr, sp, ia, pf, tf, ars, act, dend, sirq;
  logic [2:0]  rn, vm;
  logic [7:0]  len, vec;
  int          failures = 0, check_count = 0, cycles = 0;
  // Word and expected kind; reserved codes are sent on purpose.
  logic [20:0] tbl [27] = '{
    {16'h0000, CRP_K_VIOL}, {16'h3F00, CRP_K_VIOL},
    {16'h0B00, CRP_K_VIOL}, {16'h1B00, CRP_K_VIOL},
    {16'h1F00, CRP_K_VIOL}, {16'h2B00, CRP_K_VIOL},
    {16'h3B00, CRP_K_VIOL}, {16'h0201, CRP_K_VIOL},
    {16'h0110, CRP_K_CPREGS}, {16'hE110, CRP_K_CPREGS},
    {16'h0300, CRP_K_STATUS}, {16'h2504, CRP_K_TAKEADR},
    {16'h2600, CRP_K_MPREGS}, {16'h0A00, CRP_K_EVALEA},
    {16'h0C0B, CRP_K_SINGLE}, {16'h0D00, CRP_K_CTLREG},
    {16'h2E08, CRP_K_STACK}, {16'h0F06, CRP_K_ISTREAM},
    {16'h1508, CRP_K_EVALDATA}, {16'h2004, CRP_K_WRPREV},
    {16'h8903, CRP_K_NULL}, {16'h1C20, CRP_K_PREEXC},
    {16'h1D21, CRP_K_MIDEXC}, {16'h1E22, CRP_K_POSTEXC},
    {16'h0700, CRP_K_OPWORD}, {16'h8400, CRP_K_SUPCHK},
    {16'hA400, CRP_K_BUSY}
  };
  // Coprocessor model and the decoder under test.
  crp_cop_model u_crp_cop_model (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .req_in(req), .req_word_in(word), .busy_in(busy),
    .prim_valid_out(pvld), .prim_word_out(pword));
  crp_decoder u_crp_decoder (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .prim_valid_in(pvld), .prim_word_in(pword), .trace_pending_in(trace),
    .irq_pending_in(irq), .dec_valid_out(dv), .kind_out(kind),
    .protocol_violation_out(viol), .come_again_flag_out(ca),
    .pass_program_counter_flag_out(pc), .transfer_direction_flag_out(dr),
    .include_status_flag_out(sp), .interrupts_allowed_flag_out(ia),
    .processing_finished_flag_out(pf), .condition_result_flag_out(tf),
    .addr_reg_sel_out(ars), .reg_num_out(rn), .valid_mode_out(vm),
    .length_out(len), .vector_out(vec), .dialogue_active_out(act),
    .dialogue_end_out(dend), .service_irq_out(sirq));
  // Clock of 50 ns period.
  always #25 mclk_in = ~mclk_in;
  // Compare tasks for field values and for decoded kinds.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_kind(input crp_kind_t got, input crp_kind_t exp);
    chk({11'h000, got}, {11'h000, exp});
  endtask
  // Prints the verdict and ends the run.
  task automatic final_report();
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Asks the model for one word and waits until the result is settled.
  task automatic send(input logic [15:0] w);
    @(posedge mclk_in) #1;
    req = 1'b1;
    word = w;
    @(posedge mclk_in) #1;
    req = 1'b0;
    @(posedge mclk_in) #1;
    chk({15'h0000, dv}, 16'h0001);
  endtask
  // Cuts a hung run short.
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      final_report();
    end
  end
  // Main sequence.
  initial begin
    repeat (3) @(posedge mclk_in);
    #1 rst_b_in = 1'b1;
    foreach (tbl[i]) begin
      crp_kind_t k;
      k = crp_kind_t'(tbl[i][4:0]);
      send(tbl[i][20:5]);
      chk_kind(kind, k);
      chk({14'h0000, viol, dend},
          {14'h0000, k == CRP_K_VIOL, !tbl[i][20]});
    end
    send(16'hE110);
    chk({ca, pc, dr, 5'h00, len}, 16'hE010);
    send(16'h0C0B);
    chk({12'h000, ars, rn}, 16'h000B);
    send(16'h1508);
    chk({5'h00, vm, len}, 16'h0508);
    send(16'h1E22);
    chk({8'h00, vec}, 16'h0022);
    send(16'h0300);
    chk({14'h0000, sp, act}, 16'h0002);
    send(16'h8903);
    chk({12'h000, ia, pf, tf, sirq}, 16'h000E);
    irq = 1'b1;
    send(16'h8903);
    chk({13'h0000, act, sirq, dend}, 16'h0006);
    trace = 1'b1;
    busy = 1'b1;
    send(16'h0903);
    chk({13'h0000, act, sirq, dend}, 16'h0006);
    send(16'h0110);
    chk({13'h0000, act, sirq, dend}, 16'h0004);
    busy = 1'b0;
    send(16'h0903);
    chk({13'h0000, act, sirq, dend}, 16'h0001);
    send(16'h1E22);
    chk({13'h0000, act, sirq, dend}, 16'h0001);
    @(posedge mclk_in) #1;
    req = 1'b1;
    word = 16'h3F00;
    @(posedge mclk_in) #1;
    word = 16'h0110;
    @(posedge mclk_in) #1;
    req = 1'b0;
    chk({15'h0000, viol}, 16'h0001);
    @(posedge mclk_in) #1;
    chk({14'h0000, viol, dv}, 16'h0001);
    chk_kind(kind, CRP_K_CPREGS);
    @(posedge mclk_in) #1;
    chk({15'h0000, dv}, 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
